// ### design/scw_pkg.sv
// Constants, field layouts and types of the stepper control-word handler.
// Assumes a single 250 MHz clock and a 32-bit register port.
package scw_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CW_W   = 16;
  localparam int unsigned PER_W  = 13;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned QAW    = 3;
  localparam int unsigned QDEPTH = 8;
  localparam int unsigned PCW    = 20;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ACCEL  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_POS    = 8'h10;

  // ------------------------------------------------------------------
  // Control word numbers
  // ------------------------------------------------------------------
  localparam logic [CW_W-1:0] CW_ENABLE  = 16'h0001;
  localparam logic [CW_W-1:0] CW_PAUSE   = 16'h0002;
  localparam logic [CW_W-1:0] CW_CONT    = 16'h0003;
  localparam logic [CW_W-1:0] CW_ESTOP   = 16'h0004;
  localparam logic [CW_W-1:0] CW_CSTOP   = 16'h0005;
  localparam logic [CW_W-1:0] CW_STEPDIR = 16'h0006;

  // ------------------------------------------------------------------
  // Status word bit positions
  // ------------------------------------------------------------------
  localparam int unsigned ST_EN     = 0;
  localparam int unsigned ST_PAUSE  = 1;
  localparam int unsigned ST_BUSY   = 2;
  localparam int unsigned ST_CWERR  = 3;
  localparam int unsigned ST_MOVING = 4;
  localparam int unsigned ST_OVF    = 5;
  localparam int unsigned ST_DIR    = 6;
  localparam int unsigned ST_MODE   = 7;
  localparam int unsigned ST_QEMPTY = 8;
  localparam int unsigned ST_QFULL  = 9;
  localparam int unsigned ST_DECEL  = 10;
  localparam int unsigned ST_LASTCW = 16;

  // ------------------------------------------------------------------
  // Profile command fields
  // ------------------------------------------------------------------
  localparam int unsigned CMD_KIND = 30;
  localparam int unsigned CMD_DIR  = 29;
  localparam int unsigned CMD_PER  = 16;
  localparam int unsigned CMD_ARG  = 0;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [PER_W-1:0] ACCEL_RST   = 13'h0010;
  localparam logic [PER_W-1:0] STOP_PERIOD = 13'h1fff;
  localparam logic             MODE_STEPDIR = 1'b0;
  localparam int unsigned CLK_KHZ     = 250000;
  localparam int unsigned CW_PROC_US  = 3000;
  localparam int unsigned CW_PROC_CYC = CW_PROC_US * CLK_KHZ / 1000;

  typedef enum logic [1:0] {K_DIST, K_POS, K_VEL, K_BAD} scw_kind_e;
  typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_DECEL} scw_motion_e;

  function automatic logic scw_cw_valid(input logic [CW_W-1:0] cw);
    return (cw >= CW_ENABLE) && (cw <= CW_STEPDIR);
  endfunction : scw_cw_valid

endpackage : scw_pkg

// ### design/scw_step_if.sv
// Link between the motion sequencer and the step rate generator.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface scw_step_if;
  import scw_pkg::*;
  logic             run;
  logic [PER_W-1:0] period;
  logic             tick;
  modport ctl (output run, output period, input tick);
  modport gen (input run, input period, output tick);
endinterface : scw_step_if

// ### design/scw_step_gen.sv
// Step rate generator: one tick every period cycles while run is high.
// Assumes period is at least one.
`timescale 1ns/1ps
module scw_step_gen
  import scw_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  scw_step_if.gen   step
);
  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] cnt_d;
  wire              last_w;

  assign last_w    = step.run && (cnt_q + 13'h0001 >= step.period);
  assign step.tick = last_w;
  assign cnt_d     = (!step.run || last_w) ? '0 : cnt_q + 13'h0001;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cnt_q <= '0;
    else           cnt_q <= cnt_d;
  end
endmodule : scw_step_gen

// ### design/scw_cmd_queue.sv
// Profile command queue with flush; push while full is refused.
// Assumes pop is asserted only when not empty.
`timescale 1ns/1ps
module scw_cmd_queue
  import scw_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              push_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              pop_i,
  input  wire logic              flush_i,
  output logic      [DATA_W-1:0] head_o,
  output logic                   empty_o,
  output logic                   full_o
);
  logic [DATA_W-1:0] mem_q [QDEPTH];
  logic [QAW-1:0]    wp_q;
  logic [QAW-1:0]    rp_q;
  logic [QAW:0]      cnt_q;
  wire               do_push;
  wire               do_pop;

  assign empty_o = (cnt_q == '0);
  assign full_o  = (cnt_q == (QAW+1)'(QDEPTH));
  assign head_o  = mem_q[rp_q];
  assign do_push = push_i && !full_o && !flush_i;
  assign do_pop  = pop_i && !empty_o && !flush_i;

  always_ff @(posedge mclk_i) begin
    if (do_push) mem_q[wp_q] <= data_i;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + QAW'(do_push);
      rp_q  <= rp_q + QAW'(do_pop);
      cnt_q <= cnt_q + (QAW+1)'(do_push) - (QAW+1)'(do_pop);
    end
  end
endmodule : scw_cmd_queue

// ### design/scw_stepper_ctrl.sv
// Stepper control-word handler: control word decode, command queue
// sequencing, step/direction outputs and the register port.
// Assumes a single clock and a master that waits for the busy bit.
//
// Contract
// - Commands queued only after enable profile.
// - Pause stops starting further queued commands.
// - Running distance/position move finishes under pause.
// - Continue clears pause and runs next command.
// - Early continue aborts current, starts next.
// - Continue on lone velocity move decelerates.
// - Emergency stop halts pulses, empties queue.
// - Controlled stop decelerates, empties queue.
// - Word 6 selects step/direction output.
// - Step/direction is the mode after reset.
// - Busy bit held until control word applied.
// - Enable profile sets the enabled bit.
// - Listed faults and stops clear enabled.
// - Disable stops pulses, flushes, drops commands.
// - Idle status shows last control word.
`timescale 1ns/1ps
module scw_stepper_ctrl
  import scw_pkg::*;
#(
  parameter int unsigned P_CW_PROC_CYC = CW_PROC_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              scan_lost_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   step_o,
  output logic                   dir_o,
  output logic                   profile_en_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  scw_motion_e      st_q, st_d;
  scw_kind_e        kind_q;
  logic [CW_W-1:0]  cw_q;
  logic             busy_q, en_q, pause_q, cwerr_q, ovf_q, mode_q;
  logic             cs_q, dir_q, step_q;
  logic [PCW-1:0]   proc_q;
  logic [PER_W-1:0] per_q, accel_q;
  logic [CNT_W-1:0] rem_q, pos_q;
  logic [DATA_W-1:0] rdata_q;

  scw_step_if step ();
  logic [DATA_W-1:0] q_head;
  logic              q_empty, q_full;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  wire wr_ctrl  = wr_i && (addr_i == OFS_CTRL);
  wire wr_cmd   = wr_i && (addr_i == OFS_CMD);
  wire wr_accel = wr_i && (addr_i == OFS_ACCEL);

  // ------------------------------------------------------------------
  // Control word processing
  // ------------------------------------------------------------------
  wire cw_take  = wr_ctrl && !busy_q;
  wire cw_apply = busy_q && (proc_q == PCW'(P_CW_PROC_CYC - 1));
  wire cw_ok    = scw_cw_valid(cw_q);
  wire act_en    = cw_apply && (cw_q == CW_ENABLE);
  wire act_pause = cw_apply && (cw_q == CW_PAUSE);
  wire act_cont  = cw_apply && (cw_q == CW_CONT);
  wire act_estop = cw_apply && (cw_q == CW_ESTOP);
  wire act_cstop = cw_apply && (cw_q == CW_CSTOP);
  wire act_mode  = cw_apply && (cw_q == CW_STEPDIR);
  wire act_bad   = cw_apply && !cw_ok;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cw_q   <= '0;
      busy_q <= 1'b0;
      proc_q <= '0;
    end else begin
      if (cw_take) cw_q <= wdata_i[CW_W-1:0];
      busy_q <= cw_take || (busy_q && !cw_apply);
      proc_q <= busy_q && !cw_apply ? proc_q + 20'h00001 : '0;
    end
  end

  // ------------------------------------------------------------------
  // Queue and command decode
  // ------------------------------------------------------------------
  wire       q_push   = wr_cmd && en_q;
  wire       q_ovf    = q_push && q_full;
  scw_kind_e nk;
  assign nk = scw_kind_e'(q_head[CMD_KIND +: 2]);
  wire [PER_W-1:0] n_per = q_head[CMD_PER +: PER_W];
  wire [CNT_W-1:0] n_arg = q_head[CMD_ARG +: CNT_W];
  wire [CNT_W:0]   n_dlt = {n_arg[CNT_W-1], n_arg} - {pos_q[CNT_W-1], pos_q};
  wire             n_rev = (nk == K_POS) ? n_dlt[CNT_W] : q_head[CMD_DIR];
  wire [CNT_W-1:0] n_cnt = (nk != K_POS) ? n_arg :
                           n_dlt[CNT_W] ? CNT_W'(-n_dlt) : n_dlt[CNT_W-1:0];

  // A continue starts the next command at once, even mid-move.
  wire q_pop = en_q && !q_empty &&
               ((st_q == MS_IDLE && !pause_q) || act_cont);
  wire ill_cmd = q_pop && (nk == K_BAD || n_per == '0);
  wire vel_dec = act_cont && q_empty && st_q == MS_RUN && kind_q == K_VEL;

  // ------------------------------------------------------------------
  // Motion sequencer
  // ------------------------------------------------------------------
  wire [PER_W:0] per_sum  = {1'b0, per_q} + {1'b0, accel_q};
  wire           dec_end  = step.tick && (per_sum >= {1'b0, STOP_PERIOD});
  wire           cs_done  = st_q == MS_DECEL && dec_end && cs_q;
  wire           dis_ev   = act_estop || cs_done || scan_lost_i ||
                            ill_cmd || act_bad || q_ovf;
  wire           stop_now = act_estop || (en_q && dis_ev);
  wire           run_done = st_q == MS_RUN && kind_q != K_VEL &&
                            (rem_q == '0 || (step.tick && rem_q == 16'h0001));
  wire           q_flush  = act_estop || act_cstop || dis_ev;

  always_comb begin
    st_d = st_q;
    case (st_q)
      MS_IDLE: begin
        if (q_pop) st_d = MS_RUN;
      end
      MS_RUN: begin
        if (act_cstop || vel_dec) st_d = MS_DECEL;
        else if (q_pop) st_d = MS_RUN;
        else if (run_done) st_d = MS_IDLE;
      end
      MS_DECEL: begin
        if (q_pop && !cs_q) st_d = MS_RUN;
        else if (dec_end) st_d = MS_IDLE;
      end
      default: st_d = MS_IDLE;
    endcase
    if (stop_now || ill_cmd) st_d = MS_IDLE;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q   <= MS_IDLE;
      kind_q <= K_DIST;
      per_q  <= STOP_PERIOD;
      rem_q  <= '0;
      dir_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (q_pop && !(st_q == MS_DECEL && cs_q)) begin
        kind_q <= nk;
        per_q  <= n_per;
        rem_q  <= n_cnt;
        dir_q  <= n_rev;
      end else begin
        if (st_q == MS_DECEL && step.tick)
          per_q <= per_sum[PER_W] ? STOP_PERIOD : per_sum[PER_W-1:0];
        if (st_q != MS_IDLE && step.tick && rem_q != '0)
          rem_q <= rem_q - 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Profile flags
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q    <= 1'b0;
      pause_q <= 1'b0;
      cwerr_q <= 1'b0;
      ovf_q   <= 1'b0;
      cs_q    <= 1'b0;
      mode_q  <= MODE_STEPDIR;
    end else begin
      en_q    <= !dis_ev && (act_en || en_q);
      pause_q <= act_pause || (pause_q && !act_cont && !stop_now);
      cwerr_q <= act_bad || (cwerr_q && !cw_apply);
      ovf_q   <= q_ovf || (ovf_q && !act_en);
      cs_q    <= act_cstop || (cs_q && st_q != MS_IDLE && !stop_now);
      if (act_mode) mode_q <= MODE_STEPDIR;
    end
  end

  // ------------------------------------------------------------------
  // Position and pin outputs
  // ------------------------------------------------------------------
  wire step_d = step.tick && st_q != MS_IDLE && !stop_now;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_q  <= '0;
      step_q <= 1'b0;
    end else begin
      step_q <= step_d;
      if (step_d) pos_q <= dir_q ? pos_q - 16'h0001 : pos_q + 16'h0001;
    end
  end

  assign step.run    = st_q != MS_IDLE;
  assign step.period = per_q;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  wire [DATA_W-1:0] status_w = {cw_q, 5'h00, st_q == MS_DECEL, q_full,
                                q_empty, mode_q, dir_q, ovf_q,
                                st_q != MS_IDLE, cwerr_q, busy_q,
                                pause_q, en_q};
  wire [DATA_W-1:0] rd_mux =
      (addr_i == OFS_STATUS) ? status_w :
      (addr_i == OFS_ACCEL)  ? {19'h00000, accel_q} :
      (addr_i == OFS_POS)    ? {16'h0000, pos_q} : '0;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      accel_q <= ACCEL_RST;
      rdata_q <= '0;
    end else begin
      if (wr_accel) accel_q <= wdata_i[PER_W-1:0];
      // Read data stands only in the cycle after the strobe
      rdata_q <= rd_i ? rd_mux : '0;
    end
  end

  assign rdata_o      = rdata_q;
  assign step_o       = step_q;
  assign dir_o        = dir_q;
  assign profile_en_o = en_q;

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------
  scw_step_gen u_gen (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .step      (step.gen)
  );

  scw_cmd_queue u_queue (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .push_i    (q_push),
    .data_i    (wdata_i),
    .pop_i     (q_pop),
    .flush_i   (q_flush),
    .head_o    (q_head),
    .empty_o   (q_empty),
    .full_o    (q_full)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_cmd_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_cmd && !en_q && q_empty |=> q_empty)
    else $error("command queued while profile disabled");

  a_pause_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pause_q && st_q == MS_IDLE && !act_cont |=> st_q == MS_IDLE)
    else $error("command started while paused");

  a_pause_finish: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    act_pause && st_q == MS_RUN && !scan_lost_i && rem_q > 16'h0001
    |=> st_q == MS_RUN)
    else $error("pause aborted a running move");

  a_cont_next: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    act_cont && en_q && !q_empty && !scan_lost_i && !ill_cmd && !q_ovf &&
    !cs_q |=> !pause_q && st_q == MS_RUN && rem_q == $past(n_cnt))
    else $error("continue did not start next command");

  a_vel_decel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    vel_dec && !scan_lost_i |=> st_q == MS_DECEL ##1 st_q != MS_RUN)
    else $error("velocity move not decelerated on continue");

  a_estop_halt: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    act_estop |=> st_q == MS_IDLE && q_empty && !en_q && !step_o)
    else $error("emergency stop did not halt");

  a_cstop_decel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    act_cstop && st_q != MS_IDLE && !scan_lost_i |=> st_q == MS_DECEL && q_empty)
    else $error("controlled stop did not decelerate");

  a_cw_busy: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cw_take |=> busy_q && cw_q == $past(wdata_i[CW_W-1:0]))
    else $error("busy bit not set on control word");

  a_disable_stop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $fell(en_q) |-> st_q == MS_IDLE && q_empty ##1 !step_o)
    else $error("disable left motion running");

  a_mode_fixed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_q == MODE_STEPDIR)
    else $error("output mode left step/direction");

endmodule : scw_stepper_ctrl

// ### verification/scw_host_model.sv
// Controlling-processor model: register port master of the handler.
// Assumes the bench calls its tasks and that it shares the handler clock.
`timescale 1ns/1ps
module scw_host_model
  import scw_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // Released lines show the inverse so stale values are never trusted
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask : rd

  task automatic wait_idle;
    logic [DATA_W-1:0] st;
    st = '1;
    for (int k = 0; k < 64 && st[ST_BUSY] !== 1'b0; k++) begin
      rd(OFS_STATUS, st);
    end
  endtask : wait_idle

  // One numbered word; returns the status read right after it
  task automatic cw(input logic [CW_W-1:0] n, output logic [DATA_W-1:0] f);
    wait_idle();
    wr(OFS_CTRL, {16'h0000, n});
    rd(OFS_STATUS, f);
    wait_idle();
  endtask : cw
endmodule : scw_host_model

// ### verification/tb.sv
// Self-checking bench of the stepper control-word handler.
// Assumes the host model drives the register port; clock 250 MHz.
`timescale 1ns/1ps
module tb;
  import scw_pkg::*;
  localparam int unsigned P_PROC = 8;
  logic              mclk      = 1'b0;
  logic              rst       = 1'b1;
  logic              scan_lost = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              step;
  logic              dir;
  logic              prof_en;
  logic [DATA_W-1:0] s;
  int                n_mismatch  = 0;
  int                comparisons = 0;
  int                n_steps     = 0;
  int                base;

  always #2 mclk = ~mclk;

  scw_stepper_ctrl #(.P_CW_PROC_CYC(P_PROC)) scw_stepper_ctrl_inst (
    .mclk_i(mclk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .scan_lost_i(scan_lost), .rdata_o(rdata),
    .step_o(step), .dir_o(dir), .profile_en_o(prof_en));

  scw_host_model host (
    .mclk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  always @(posedge mclk) begin
    if (step === 1'b1) begin
      n_steps <= n_steps + 1;
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string w, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic st;
    host.rd(OFS_STATUS, s);
  endtask : st

  function automatic logic [DATA_W-1:0] mk(input logic [1:0] k,
      input logic d, input logic [PER_W-1:0] p, input logic [15:0] c);
    return {k, d, p, c};
  endfunction : mk

  task automatic stop_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    st();
    chk("status", 32'h00000100, s);
    host.rd(8'h14, s);
    chk("unmapped", 32'h00000000, s);
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0002));
    idle(40);
    chk("steps", 32'h0, 32'(n_steps));
    host.rd(OFS_ACCEL, s);
    chk("accel", 32'h00000010, s);
    host.wr(OFS_ACCEL, 32'h00001000);
    host.rd(OFS_ACCEL, s);
    chk("accel", 32'h00001000, s);
  endtask : t_reset

  task automatic t_enable;
    host.cw(CW_ENABLE, s);
    chk("busy", 1'h1, s[ST_BUSY]);
    st();
    chk("status", 32'h00010101, s);
    chk("prof_en", 1'h1, prof_en);
  endtask : t_enable

  task automatic t_move;
    base = n_steps;
    host.wr(OFS_CMD, mk(K_DIST, 1'b1, 13'h0004, 16'h0003));
    idle(40);
    chk("steps", 32'h3, 32'(n_steps - base));
    chk("dir", 1'h1, dir);
    host.rd(OFS_POS, s);
    chk("pos", 32'h0000fffd, {16'h0000, s[15:0]});
    host.cw(CW_STEPDIR, s);
    st();
    chk("mode", 1'h0, s[ST_MODE]);
    chk("last", 16'h0006, s[31:16]);
  endtask : t_move

  task automatic t_pause;
    base = n_steps;
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0010, 16'h0004));
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0010, 16'h0002));
    host.cw(CW_PAUSE, s);
    idle(120);
    st();
    chk("steps", 32'h4, 32'(n_steps - base));
    chk("paused", 1'h1, s[ST_PAUSE]);
    host.cw(CW_CONT, s);
    idle(60);
    st();
    chk("steps", 32'h6, 32'(n_steps - base));
    chk("paused", 1'h0, s[ST_PAUSE]);
  endtask : t_pause

  task automatic t_abort;
    base = n_steps;
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0008, 16'h00c8));
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0008, 16'h0001));
    idle(40);
    host.cw(CW_CONT, s);
    idle(30);
    st();
    chk("moving", 1'h0, s[ST_MOVING]);
    chk("qempty", 1'h1, s[ST_QEMPTY]);
    chk("short", 1'h1, (n_steps - base) < 20);
  endtask : t_abort

  // Velocity move stopped by continue or by controlled stop
  task automatic t_decel(input logic [CW_W-1:0] n, input logic en_after);
    host.wr(OFS_CMD, mk(K_VEL, 1'b0, 13'h0004, 16'h0000));
    if (n == CW_CSTOP) begin
      host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0004));
    end
    idle(20);
    host.cw(n, s);
    st();
    chk("decel", 1'h1, s[ST_DECEL]);
    chk("qempty", 1'h1, s[ST_QEMPTY]);
    idle(5000);
    st();
    chk("moving", 1'h0, s[ST_MOVING]);
    chk("prof_en", en_after, prof_en);
  endtask : t_decel

  task automatic t_estop;
    host.cw(CW_ENABLE, s);
    host.wr(OFS_CMD, mk(K_VEL, 1'b0, 13'h0004, 16'h0000));
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0004));
    idle(20);
    host.cw(CW_ESTOP, s);
    base = n_steps;
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0002));
    idle(60);
    st();
    chk("steps", 32'h0, 32'(n_steps - base));
    chk("status", 32'h00040100, s);
  endtask : t_estop

  task automatic t_bad;
    logic [CW_W-1:0] bad [2] = '{16'h0000, 16'h0007};
    foreach (bad[i]) begin
      host.cw(CW_ENABLE, s);
      host.cw(bad[i], s);
      st();
      chk("cw_err", 1'h1, s[ST_CWERR]);
      chk("prof_en", 1'h0, prof_en);
    end
  endtask : t_bad

  task automatic t_ovf;
    host.cw(CW_ENABLE, s);
    host.cw(CW_PAUSE, s);
    repeat (QDEPTH) host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0001));
    st();
    chk("qfull", 1'h1, s[ST_QFULL]);
    host.wr(OFS_CMD, mk(K_DIST, 1'b0, 13'h0004, 16'h0001));
    st();
    chk("ovf", 1'h1, s[ST_OVF]);
    chk("qempty", 1'h1, s[ST_QEMPTY]);
    chk("prof_en", 1'h0, prof_en);
  endtask : t_ovf

  task automatic t_scan;
    host.cw(CW_ENABLE, s);
    @(posedge mclk);
    scan_lost <= 1'b1;
    idle(4);
    chk("prof_en", 1'h0, prof_en);
    scan_lost <= 1'b0;
  endtask : t_scan

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    idle(16);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_move();
    t_pause();
    t_abort();
    t_decel(CW_CONT, 1'b1);
    t_decel(CW_CSTOP, 1'b0);
    t_estop();
    t_bad();
    t_ovf();
    t_scan();
    stop_test();
  end

  initial begin
    idle(40000);
    n_mismatch++;
    stop_test();
  end
endmodule : tb
